// file: rtl/alert_consts.svh
// Register map, field positions, reset values and timing of the alert pin block
//
// Behaviour
// - Alert pin drive style from 3-bit field
// - Pin function 3 outputs manual level bit
// - Pin function 0 disables pin and buffers
// - Pin function 1 drives pin from interrupt
// - Function 3 is general output; 2, 5, 6 and 7 reserved
// - Function 4 outputs divided modulation input clock
// - Pin configuration resets to 0x21
// - Style 0: one 2 ms high pulse
// - Style 1: 2 ms pulses, 4 ms period
// - Style 2: held high until latches read
// - Enable bit 7 gates overcurrent event
// - Enable bit 6 gates analog undervoltage event
// - Enable bit 5 gates clock fault b
// - Enable bit 4 gates over-temperature event
// - Enable bit 3 gates brownout event
// - Enable bit 2 gates clock fault a
// - Enable bit 1 gates modulator clock halt
// - Enable bit 0 gates frame clock halt
// - All enable bits reset to zero
// - Events latch sticky until register read
// - Latch bit layout of both latch registers
`ifndef ALERT_CONSTS_SVH
`define ALERT_CONSTS_SVH

// ****************************************
// Register offsets and reset values
// ****************************************
`define OFS_ALERT_PIN_CONFIG        8'h23
`define OFS_ALERT_SIGNALLING_CONFIG 8'h24
`define OFS_EVENT_ENABLE_MASK       8'h25
`define OFS_EVENT_LATCH_A           8'h26
`define OFS_EVENT_LATCH_B           8'h27
`define RST_ALERT_PIN_CONFIG        8'h21
`define RST_ALERT_SIGNALLING_CONFIG 8'h00
`define RST_EVENT_ENABLE_MASK       8'h00
`define RST_EVENT_LATCH             8'h00
`define RDATA_UNMAPPED              8'h00

// ****************************************
// Field positions
// ****************************************
`define DRIVE_STYLE_HI              7
`define DRIVE_STYLE_LO              5
`define ALERT_PIN_MANUAL_LEVEL_BIT  4
`define PIN_FUNCTION_HI             2
`define PIN_FUNCTION_LO             0
`define ALERT_SIGNALLING_STYLE_HI   7
`define ALERT_SIGNALLING_STYLE_LO   6

// ****************************************
// Field codes
// ****************************************
`define DRIVE_PUSH_PULL             3'h0
`define DRIVE_OD_LOW                3'h1
`define DRIVE_OD_HIGH               3'h2
`define DRIVE_OD_LOW_PULLUP         3'h3
`define DRIVE_OD_HIGH_PULLDOWN      3'h4
`define FUNC_DISABLED               3'h0
`define FUNC_INTERRUPT              3'h1
`define FUNC_MANUAL_OUTPUT          3'h3
`define FUNC_DIVIDED_CLOCK          3'h4
`define STYLE_SINGLE_PULSE          2'h0
`define STYLE_REPEAT_PULSE          2'h1
`define STYLE_HELD_LEVEL            2'h2

// ****************************************
// Timing
// ****************************************
`define CLK_MHZ                     125
`define PULSE_US                    2000
`define PERIOD_US                   4000
`define CNT_W                       20

`endif

// file: rtl/alert_pkg.sv
// Types shared by the alert pin block
`include "alert_consts.svh"
package alert_pkg;

    // Interrupt signalling sequencer, one-hot
    typedef enum logic [4:0] {
        IDLE   = 5'h01,
        PULSE  = 5'h02,
        REP_HI = 5'h04,
        REP_LO = 5'h08,
        HOLD   = 5'h10
    } fsm_t;

    // Fault event pulses from the detectors
    typedef struct packed {
        logic overcurrent;
        logic analog_undervoltage;
        logic clock_fault_a;
        logic overtemp;
        logic brownout;
        logic clock_fault_b;
        logic measurement_done;
        logic frame_clock_halt;
        logic modulator_clock_halt;
    } event_t;

    // Register access request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    // Alert pin pad controls
    typedef struct packed {
        logic out;
        logic oe;
        logic pu_en;
        logic pd_en;
        logic buf_en;
    } pin_t;

    // Whole state of the block
    typedef struct packed {
        logic [7:0]        pin_cfg;
        logic [7:0]        sig_cfg;
        logic [7:0]        mask;
        logic [7:0]        latch_a;
        logic [7:0]        latch_b;
        fsm_t              fsm;
        logic [`CNT_W-1:0] cnt;
        logic              pend_prev;
        logic [7:0]        rdata;
        pin_t              pin;
    } state_t;

endpackage

// file: rtl/fault_irq_pin_control.sv
// Alert pin control: event latches, enables, signalling sequencer and pad drive
`timescale 1ns/100ps
`include "alert_consts.svh"
module fault_irq_pin_control #(
    parameter int unsigned PULSE_CYC  = `PULSE_US * `CLK_MHZ,
    parameter int unsigned PERIOD_CYC = `PERIOD_US * `CLK_MHZ
) (
    // Clock and reset
    input  wire logic                clk_sys,
    input  wire logic                arst_n,
    // Register access
    input  wire alert_pkg::reg_req_t reg_req,
    output logic [7:0]               reg_rdata,
    // Fault detector events
    input  wire alert_pkg::event_t   events,
    input  wire logic                modulation_input_divided_clock,
    // Alert pad
    output alert_pkg::pin_t          alert_pin
);

    localparam logic [`CNT_W-1:0] PULSE_LAST = `CNT_W'(PULSE_CYC - 1);
    localparam logic [`CNT_W-1:0] LOW_LAST   = `CNT_W'(PERIOD_CYC - PULSE_CYC - 1);

    alert_pkg::state_t st_r;
    alert_pkg::state_t st_nxt;

    // ****************************************
    // Helper functions
    // ****************************************

    // Latched flags that are allowed through, matched event by event since
    // the enable bits are not in latch order
    function automatic logic enabled_pending(input logic [7:0] la,
                                             input logic [7:0] lb,
                                             input logic [7:0] m);
        logic [7:0] hit;
        hit[7] = la[7] & m[7];
        hit[6] = la[6] & m[6];
        hit[5] = la[2] & m[5];
        hit[4] = la[4] & m[4];
        hit[3] = la[3] & m[3];
        hit[2] = la[5] & m[2];
        hit[1] = lb[6] & m[1];
        hit[0] = lb[7] & m[0];
        return |hit;
    endfunction

    // Pad controls for a wanted level under a drive style
    function automatic alert_pkg::pin_t pad_drive(input logic [2:0] style,
                                                  input logic       lvl);
        alert_pkg::pin_t p;
        p = '0;
        p.buf_en = 1'b1;
        case (style)
            `DRIVE_PUSH_PULL: begin
                p.out = lvl;
                p.oe  = 1'b1;
            end
            `DRIVE_OD_LOW, `DRIVE_OD_LOW_PULLUP: begin
                p.out   = 1'b0;
                p.oe    = ~lvl;
                p.pu_en = (style == `DRIVE_OD_LOW_PULLUP);
            end
            `DRIVE_OD_HIGH, `DRIVE_OD_HIGH_PULLDOWN: begin
                p.out   = 1'b1;
                p.oe    = lvl;
                p.pd_en = (style == `DRIVE_OD_HIGH_PULLDOWN);
            end
            // Reserved styles keep the pad off rather than guess a drive
            default: p.oe = 1'b0;
        endcase
        return p;
    endfunction

    // ****************************************
    // Decoded fields and strobes
    // ****************************************
    logic [2:0] drive_style;
    logic [2:0] pin_function;
    logic [1:0] signalling_style;
    logic       manual_level;
    logic       rd_a_hit;
    logic       rd_b_hit;
    logic [7:0] ev_a;
    logic [7:0] ev_b;
    logic       pend;
    logic       any_flag;
    logic       trigger;
    logic       irq_level;

    // Field taps and event packing into latch layout
    assign drive_style      = st_r.pin_cfg[`DRIVE_STYLE_HI:`DRIVE_STYLE_LO];
    assign pin_function     = st_r.pin_cfg[`PIN_FUNCTION_HI:`PIN_FUNCTION_LO];
    assign manual_level     = st_r.pin_cfg[`ALERT_PIN_MANUAL_LEVEL_BIT];
    assign signalling_style = st_r.sig_cfg[`ALERT_SIGNALLING_STYLE_HI:`ALERT_SIGNALLING_STYLE_LO];
    assign rd_a_hit = reg_req.rd && (reg_req.addr == `OFS_EVENT_LATCH_A);
    assign rd_b_hit = reg_req.rd && (reg_req.addr == `OFS_EVENT_LATCH_B);
    assign ev_a = {events.overcurrent, events.analog_undervoltage, events.clock_fault_a,
                   events.overtemp, events.brownout, events.clock_fault_b,
                   events.measurement_done, 1'b0};
    assign ev_b = {events.frame_clock_halt, events.modulator_clock_halt, 6'h00};
    assign pend      = enabled_pending(st_r.latch_a, st_r.latch_b, st_r.mask);
    assign any_flag  = (|st_r.latch_a) | (|st_r.latch_b);
    assign trigger   = pend & ~st_r.pend_prev;
    assign irq_level = (st_r.fsm == alert_pkg::PULSE) || (st_r.fsm == alert_pkg::REP_HI) ||
                       (st_r.fsm == alert_pkg::HOLD);

    // ****************************************
    // Next state
    // ****************************************

    // Registers, latches, sequencer and pad in one place
    always_comb begin
        logic lvl;
        lvl    = 1'b0;
        st_nxt = st_r;
        st_nxt.pend_prev = pend;

        // Configuration writes; latch registers are read only
        if (reg_req.wr) begin
            case (reg_req.addr)
                `OFS_ALERT_PIN_CONFIG:        st_nxt.pin_cfg = reg_req.wdata;
                `OFS_ALERT_SIGNALLING_CONFIG: st_nxt.sig_cfg = reg_req.wdata;
                `OFS_EVENT_ENABLE_MASK:       st_nxt.mask    = reg_req.wdata;
                default:                      st_nxt.pin_cfg = st_r.pin_cfg;
            endcase
        end

        // Read data, unmapped reads answer zero
        if (reg_req.rd) begin
            case (reg_req.addr)
                `OFS_ALERT_PIN_CONFIG:        st_nxt.rdata = st_r.pin_cfg;
                `OFS_ALERT_SIGNALLING_CONFIG: st_nxt.rdata = st_r.sig_cfg;
                `OFS_EVENT_ENABLE_MASK:       st_nxt.rdata = st_r.mask;
                `OFS_EVENT_LATCH_A:           st_nxt.rdata = st_r.latch_a;
                `OFS_EVENT_LATCH_B:           st_nxt.rdata = st_r.latch_b;
                default:                      st_nxt.rdata = `RDATA_UNMAPPED;
            endcase
        end

        // Sticky latches: read clears, but an event in the same cycle wins
        st_nxt.latch_a = (rd_a_hit ? 8'h00 : st_r.latch_a) | ev_a;
        st_nxt.latch_b = (rd_b_hit ? 8'h00 : st_r.latch_b) | ev_b;

        // Signalling sequencer
        st_nxt.cnt = st_r.cnt + `CNT_W'(1);
        case (st_r.fsm)
            alert_pkg::IDLE: begin
                st_nxt.cnt = '0;
                if (trigger) begin
                    case (signalling_style)
                        `STYLE_REPEAT_PULSE: st_nxt.fsm = alert_pkg::REP_HI;
                        `STYLE_HELD_LEVEL:   st_nxt.fsm = alert_pkg::HOLD;
                        default:             st_nxt.fsm = alert_pkg::PULSE;
                    endcase
                end
            end
            alert_pkg::PULSE: begin
                // A new trigger during the pulse merges into it
                if (st_r.cnt == PULSE_LAST) begin
                    st_nxt.fsm = alert_pkg::IDLE;
                    st_nxt.cnt = '0;
                end
            end
            alert_pkg::REP_HI: begin
                if (!any_flag) begin
                    st_nxt.fsm = alert_pkg::IDLE;
                    st_nxt.cnt = '0;
                end else if (st_r.cnt == PULSE_LAST) begin
                    st_nxt.fsm = alert_pkg::REP_LO;
                    st_nxt.cnt = '0;
                end
            end
            alert_pkg::REP_LO: begin
                if (!any_flag) begin
                    st_nxt.fsm = alert_pkg::IDLE;
                    st_nxt.cnt = '0;
                end else if (st_r.cnt == LOW_LAST) begin
                    st_nxt.fsm = alert_pkg::REP_HI;
                    st_nxt.cnt = '0;
                end
            end
            alert_pkg::HOLD: begin
                st_nxt.cnt = '0;
                if (!any_flag) begin
                    st_nxt.fsm = alert_pkg::IDLE;
                end
            end
            default: begin
                st_nxt.fsm = alert_pkg::IDLE;
                st_nxt.cnt = '0;
            end
        endcase

        // Pad drive by pin function; reserved codes leave the pad powered down
        case (pin_function)
            `FUNC_INTERRUPT: begin
                lvl = irq_level;
                st_nxt.pin = pad_drive(drive_style, lvl);
            end
            `FUNC_MANUAL_OUTPUT: begin
                lvl = manual_level;
                st_nxt.pin = pad_drive(drive_style, lvl);
            end
            `FUNC_DIVIDED_CLOCK: begin
                lvl = modulation_input_divided_clock;
                st_nxt.pin = pad_drive(drive_style, lvl);
            end
            default: st_nxt.pin = '0;
        endcase
    end

    // ****************************************
    // State register
    // ****************************************

    // All state in one register so reset values sit together
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st_r           <= '0;
            st_r.pin_cfg   <= `RST_ALERT_PIN_CONFIG;
            st_r.sig_cfg   <= `RST_ALERT_SIGNALLING_CONFIG;
            st_r.mask      <= `RST_EVENT_ENABLE_MASK;
            st_r.latch_a   <= `RST_EVENT_LATCH;
            st_r.latch_b   <= `RST_EVENT_LATCH;
            st_r.fsm       <= alert_pkg::IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs come straight from the state register
    assign reg_rdata = st_r.rdata;
    assign alert_pin = st_r.pin;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    a_mask_blocks_irq: assert property (
        (st_r.mask == 8'h00 && st_r.fsm == alert_pkg::IDLE) |=> st_r.fsm == alert_pkg::IDLE)
        else $error("interrupt started with every event disabled");

    a_pulse_bounded: assert property (
        (st_r.fsm == alert_pkg::PULSE || st_r.fsm == alert_pkg::REP_HI) |-> st_r.cnt <= PULSE_LAST)
        else $error("alert pulse longer than its set width");

    a_hold_stays: assert property (
        (st_r.fsm == alert_pkg::HOLD && any_flag) |=> st_r.fsm == alert_pkg::HOLD)
        else $error("held alert dropped while flags remain");

    a_hold_release: assert property (
        (st_r.fsm == alert_pkg::HOLD && !any_flag) |=> st_r.fsm == alert_pkg::IDLE)
        else $error("held alert kept after latches cleared");

    a_manual_level: assert property (
        (pin_function == `FUNC_MANUAL_OUTPUT && drive_style == `DRIVE_PUSH_PULL)
        |=> (alert_pin.oe && alert_pin.out == $past(manual_level)))
        else $error("manual level not on pad");

    a_disabled_pad: assert property (
        pin_function == `FUNC_DISABLED |=> !alert_pin.oe && !alert_pin.buf_en)
        else $error("disabled pad still active");

    a_latch_sticky: assert property (
        !rd_a_hit |=> (st_r.latch_a & $past(st_r.latch_a)) == $past(st_r.latch_a))
        else $error("latch flag lost without read");

    a_read_clears: assert property (
        (rd_a_hit && ev_a == 8'h00) |=> st_r.latch_a == 8'h00)
        else $error("latch read did not clear");

    a_od_low_drive: assert property (
        drive_style == `DRIVE_OD_LOW |=> (!alert_pin.oe || alert_pin.out == 1'b0))
        else $error("open drain low style drove high");

    a_trigger_starts: assert property (
        (st_r.fsm == alert_pkg::IDLE && trigger) |=> st_r.fsm != alert_pkg::IDLE)
        else $error("enabled event did not start signalling");

    a_od_high_drive: assert property (
        drive_style == `DRIVE_OD_HIGH |=> (!alert_pin.oe || alert_pin.out))
        else $error("open drain high style drove low");

    a_pull_up_on: assert property (
        (drive_style == `DRIVE_OD_LOW_PULLUP && pin_function == `FUNC_MANUAL_OUTPUT)
        |=> alert_pin.pu_en && !alert_pin.pd_en)
        else $error("pull-up style without pull-up");

    a_pull_down_on: assert property (
        (drive_style == `DRIVE_OD_HIGH_PULLDOWN && pin_function == `FUNC_MANUAL_OUTPUT)
        |=> alert_pin.pd_en && !alert_pin.pu_en)
        else $error("pull-down style without pull-down");

    a_irq_on_pad: assert property (
        (pin_function == `FUNC_INTERRUPT && drive_style == `DRIVE_PUSH_PULL)
        |=> alert_pin.out == $past(irq_level))
        else $error("interrupt level not on pad");

    a_clock_on_pad: assert property (
        (pin_function == `FUNC_DIVIDED_CLOCK && drive_style == `DRIVE_PUSH_PULL)
        |=> alert_pin.out == $past(modulation_input_divided_clock))
        else $error("divided clock not on pad");

    a_unused_pad: assert property (
        (pin_function != `FUNC_INTERRUPT && pin_function != `FUNC_MANUAL_OUTPUT &&
         pin_function != `FUNC_DIVIDED_CLOCK) |=> alert_pin == '0)
        else $error("reserved pin function drove the pad");

    a_latch_b_sticky: assert property (
        !rd_b_hit |=> (st_r.latch_b & $past(st_r.latch_b)) == $past(st_r.latch_b))
        else $error("second latch flag lost without read");

    a_read_clears_b: assert property (
        (rd_b_hit && ev_b == 8'h00) |=> st_r.latch_b == 8'h00)
        else $error("second latch read did not clear");

    a_event_sets: assert property (
        ev_a != 8'h00 |=> (st_r.latch_a & $past(ev_a)) == $past(ev_a))
        else $error("event lost against a read");

    a_repeat_gap: assert property (
        (st_r.fsm == alert_pkg::REP_LO && st_r.cnt == LOW_LAST && any_flag)
        |=> st_r.fsm == alert_pkg::REP_HI)
        else $error("repeating alert did not restart");

    a_repeat_stops: assert property (
        ((st_r.fsm == alert_pkg::REP_HI || st_r.fsm == alert_pkg::REP_LO) && !any_flag)
        |=> st_r.fsm == alert_pkg::IDLE)
        else $error("repeating alert kept after latches cleared");

    a_held_entry: assert property (
        (st_r.fsm == alert_pkg::IDLE && trigger && signalling_style == `STYLE_HELD_LEVEL)
        |=> st_r.fsm == alert_pkg::HOLD)
        else $error("held style did not hold");

    // Main scenarios, to see that each one was reached
    c_single_pulse: cover property (st_r.fsm == alert_pkg::PULSE ##1 st_r.fsm == alert_pkg::IDLE);
    c_repeat_pulse: cover property (st_r.fsm == alert_pkg::REP_LO ##1
                                    st_r.fsm == alert_pkg::REP_HI);
    c_held_level:   cover property (st_r.fsm == alert_pkg::HOLD ##1 st_r.fsm == alert_pkg::IDLE);
    c_masked_event: cover property (any_flag && !pend);
    c_clock_on_pad: cover property (pin_function == `FUNC_DIVIDED_CLOCK && alert_pin.oe);

endmodule

// file: sim/host_irq_line.sv
// Host interrupt input model: resolves the alert pad level seen by the host
`timescale 1ns/100ps
module host_irq_line (
    // Clock and reset
    input  wire logic            clk_sys,
    input  wire logic            arst_n,
    // Alert pad from the device
    input  wire alert_pkg::pin_t alert_pin,
    // Line level at the host
    output logic                 irq_level,
    output logic                 irq_floating
);
    logic wander_r;

    // An undriven, unpulled line must not look settled, so it wanders
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wander_r <= 1'b0;
        end else begin
            wander_r <= ~wander_r;
        end
    end

    // Driver beats pulls, pulls beat a floating line
    always_comb begin
        irq_floating = 1'b0;
        if (alert_pin.oe) begin
            irq_level = alert_pin.out;
        end else if (alert_pin.pu_en) begin
            irq_level = 1'b1;
        end else if (alert_pin.pd_en) begin
            irq_level = 1'b0;
        end else begin
            irq_level    = wander_r;
            irq_floating = 1'b1;
        end
    end
endmodule

// file: sim/fault_irq_pin_control_tb_top.sv
// Self-checking bench for the alert pin block
`timescale 1ns/100ps
module fault_irq_pin_control_tb_top;
    logic                clk_sys;
    logic                arst_n;
    alert_pkg::reg_req_t req;
    logic [8:0]          ev;
    logic                div_clk;
    logic [7:0]          reg_rdata;
    alert_pkg::pin_t     alert_pin;
    logic                irq_level;
    logic                irq_floating;
    int                  bad_count;
    int                  samples_checked;
    int                  cyc;
    // Enable bit to event bit position, and expected latch value per enable bit
    int                  evi [8] = '{1, 0, 6, 4, 5, 3, 7, 8};
    logic [7:0]          lv  [8] = '{8'h80, 8'h40, 8'h20, 8'h08, 8'h10, 8'h04, 8'h40, 8'h80};

    // Short counts keep the pulse runs brief
    fault_irq_pin_control #(.PULSE_CYC(4), .PERIOD_CYC(10)) u_fault_irq_pin_control (
        .clk_sys                        (clk_sys),
        .arst_n                         (arst_n),
        .reg_req                        (req),
        .reg_rdata                      (reg_rdata),
        .events                         (alert_pkg::event_t'(ev)),
        .modulation_input_divided_clock (div_clk),
        .alert_pin                      (alert_pin)
    );
    host_irq_line u_host_irq_line (
        .clk_sys      (clk_sys),
        .arst_n       (arst_n),
        .alert_pin    (alert_pin),
        .irq_level    (irq_level),
        .irq_floating (irq_floating)
    );

    // Clock
    always #4 clk_sys = ~clk_sys;

    // Hang guard
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            summarize();
        end
    end

    task automatic summarize();
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        req.wr    = 1'b1;
        req.addr  = a;
        req.wdata = d;
        @(negedge clk_sys);
        req.wr = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk_sys);
        req.rd   = 1'b1;
        req.addr = a;
        @(negedge clk_sys);
        req.rd = 1'b0;
        check(reg_rdata, e);
    endtask

    // One-cycle pulse on one event input
    task automatic fire(input int idx);
        @(negedge clk_sys);
        ev[idx] = 1'b1;
        @(negedge clk_sys);
        ev = 9'h000;
    endtask

    task automatic hi_count(input int n, output int c);
        c = 0;
        repeat (n) begin
            @(negedge clk_sys);
            if (alert_pin.out === 1'b1) c++;
        end
    endtask

    task automatic run_len(input logic lvl, output int n);
        n = 0;
        while (alert_pin.out === lvl && n < 50) begin
            n++;
            @(negedge clk_sys);
        end
    endtask

    // Reset values, read-only latches and an unmapped place
    task automatic t_reset();
        @(negedge clk_sys);
        check(8'(alert_pin), 8'h09);
        rd(8'h23, 8'h21);
        rd(8'h24, 8'h00);
        rd(8'h25, 8'h00);
        rd(8'h26, 8'h00);
        rd(8'h27, 8'h00);
        wr(8'h26, 8'hff);
        wr(8'h30, 8'hff);
        rd(8'h26, 8'h00);
        rd(8'h30, 8'h00);
        wr(8'h25, 8'hff);
        rd(8'h25, 8'hff);
        wr(8'h24, 8'hff);
        rd(8'h24, 8'hff);
    endtask

    // Every drive style at both manual levels
    task automatic t_drive();
        logic [4:0] e;
        logic [4:0] m;
        for (int d = 0; d < 8; d++) begin
            for (int l = 0; l < 2; l++) begin
                wr(8'h23, {d[2:0], l[0], 4'hb});
                @(negedge clk_sys);
                m = (d > 4) ? 5'h09 : 5'h1f;
                case (d)
                    0: e = {l[0], 1'b1, 3'b001};
                    1: e = {1'b0, ~l[0], 3'b001};
                    2: e = {1'b1, l[0], 3'b001};
                    3: e = {1'b0, ~l[0], 3'b101};
                    4: e = {1'b1, l[0], 3'b011};
                    default: e = 5'h01;
                endcase
                check(8'(alert_pin & m), 8'(e));
                rd(8'h23, {d[2:0], l[0], 4'hb});
            end
        end
    endtask

    // Disabled and reserved functions leave the pad dead; divided clock is copied
    task automatic t_func();
        for (int f = 0; f < 8; f++) begin
            if (f inside {0, 2, 5, 6, 7}) begin
                wr(8'h23, {5'h10, f[2:0]});
                @(negedge clk_sys);
                check(8'(alert_pin), 8'h00);
                check(8'(irq_floating), 8'h01);
            end
        end
        wr(8'h23, 8'h04);
        for (int i = 0; i < 4; i++) begin
            div_clk = i[0];
            repeat (2) @(negedge clk_sys);
            check(8'({alert_pin.out, alert_pin.oe}), {6'h00, i[0], 1'b1});
        end
    endtask

    // Held level from one event; checks gating, latch layout and clear on read
    task automatic t_event(input int idx, input logic [7:0] m, input logic hit,
                           input logic [7:0] ea, input logic [7:0] eb);
        wr(8'h25, m);
        fire(idx);
        repeat (3) @(negedge clk_sys);
        check(8'(alert_pin.out), 8'(hit));
        check(8'(irq_level), 8'(hit));
        rd(8'h26, ea);
        rd(8'h27, eb);
        repeat (3) @(negedge clk_sys);
        check(8'(alert_pin.out), 8'h00);
        rd(8'h26, 8'h00);
    endtask

    task automatic t_masks();
        wr(8'h23, 8'h01);
        wr(8'h24, 8'h80);
        for (int b = 0; b < 8; b++) begin
            t_event(evi[b], 8'h01 << b, 1'b1, (b > 1) ? lv[b] : 8'h00,
                    (b < 2) ? lv[b] : 8'h00);
            t_event(evi[b], ~(8'h01 << b), 1'b0, (b > 1) ? lv[b] : 8'h00,
                    (b < 2) ? lv[b] : 8'h00);
        end
        t_event(2, 8'hff, 1'b0, 8'h02, 8'h00);
    endtask

    // Single pulse length, then repeating pulses until both latches are read
    task automatic t_styles();
        int c;
        wr(8'h24, 8'h00);
        wr(8'h25, 8'hff);
        fire(8);
        hi_count(20, c);
        check(8'(c), 8'h04);
        rd(8'h26, 8'h80);
        rd(8'h27, 8'h00);
        wr(8'h24, 8'h40);
        fire(5);
        for (int k = 0; k < 10 && alert_pin.out !== 1'b1; k++) @(negedge clk_sys);
        run_len(1'b1, c);
        check(8'(c), 8'h04);
        run_len(1'b0, c);
        check(8'(c), 8'h06);
        run_len(1'b1, c);
        check(8'(c), 8'h04);
        rd(8'h26, 8'h10);
        rd(8'h27, 8'h00);
        hi_count(25, c);
        check(8'(c), 8'h00);
    endtask

    // Reset in mid-run must bring changed registers back to their reset values
    task automatic t_reset_again();
        @(negedge clk_sys);
        arst_n = 1'b0;
        repeat (2) @(negedge clk_sys);
        check(8'(alert_pin), 8'h00);
        arst_n = 1'b1;
        @(negedge clk_sys);
        check(8'(alert_pin), 8'h09);
        rd(8'h23, 8'h21);
        rd(8'h24, 8'h00);
        rd(8'h25, 8'h00);
    endtask

    // Main sequence
    initial begin
        clk_sys         = 1'b0;
        arst_n          = 1'b0;
        req             = '0;
        ev              = 9'h000;
        div_clk         = 1'b0;
        bad_count       = 0;
        samples_checked = 0;
        cyc             = 0;
        repeat (12) @(posedge clk_sys);
        @(negedge clk_sys);
        arst_n = 1'b1;
        t_reset();
        t_drive();
        t_func();
        t_masks();
        t_styles();
        t_reset_again();
        summarize();
    end
endmodule
